// file: logic/hm_pkg.sv
// hardware monitor control and status: shared offsets, fields, reset values, timing
// assumes a 100 MHz ref_clk; every use is written hm_pkg::name
package hm_pkg;

  // register offsets reached through the address pointer
  localparam logic [7:0] ADDR_CHANNEL_MODE = 8'h16;
  localparam logic [7:0] ADDR_CONFIG       = 8'h40;
  localparam logic [7:0] ADDR_STATUS1      = 8'h41;
  localparam logic [7:0] ADDR_STATUS2      = 8'h42;

  // reset values
  localparam logic [7:0] RST_POINTER      = 8'h00;
  localparam logic [7:0] RST_CHANNEL_MODE = 8'h08;
  localparam logic [7:0] RST_CONFIG       = 8'h08;
  localparam logic [7:0] RST_STATUS       = 8'h00;

  // channel mode fields
  localparam int CM_IN1_ANALOG = 0;
  localparam int CM_IN2_ANALOG = 1;
  localparam int CM_DIODE2     = 2;
  localparam int CM_RANGE_5V   = 3;
  localparam int CM_REQ0_EN    = 4;
  localparam int CM_REQ_SELECT = 7;

  // configuration fields
  localparam int CFG_START      = 0;
  localparam int CFG_INT_EN     = 1;
  localparam int CFG_THERMAL_ALARM_N_EN   = 2;
  localparam int CFG_INT_CLEAR  = 3;
  localparam int CFG_RESET_OUT  = 4;
  localparam int CFG_THERMAL_ALARM_N_HOLD = 6;
  localparam int CFG_DEFAULTS   = 7;

  // first and second status fields; second status bits 2 and 3 read as zero
  localparam int ST1_INT_TEMP  = 4;
  localparam int ST1_EXT_TEMP  = 5;
  localparam int ST1_IN1       = 6;
  localparam int ST2_CASE_OPEN = 4;
  localparam int ST2_THERMAL   = 5;
  localparam int ST2_DIODE1    = 6;
  localparam int ST2_DIODE2    = 7;

  // reset output pulse: least time, so the count is exact or rounded up
  localparam int unsigned RESET_PULSE_MS     = 20;
  localparam int unsigned REF_CLK_KHZ        = 100_000;
  localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_MS * REF_CLK_KHZ;

  // kind of access carried from the link side
  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_PTR   = 2'b01,
    OP_WRITE = 2'b10
  } hm_op_type;

  // link side handshake states
  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_WAIT = 2'b10
  } hm_link_state_type;

endpackage

// file: logic/hm_sync_bus.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit changes rarely; bits are not coherent as a word
`timescale 1ns/1ps
module hm_sync_bus #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // levels from another domain, synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q_q    <= '0;
    end
    else
    begin
      meta_q <= d;
      q_q    <= meta_q;
    end
  end

  assign q = q_q;

endmodule

// file: logic/hm_pulse_timer.sv
// fixed length pulse timer: active for exactly CYCLES clocks after start
// assumes start is a one cycle pulse; a start while active is ignored
`timescale 1ns/1ps
module hm_pulse_timer #(
  parameter int unsigned CYCLES = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // trigger and running flag
  input  wire logic start,
  output logic      active
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         active_q;

  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != '0)
      cnt_d = cnt_q - W'(1);
    else if (start)
      cnt_d = W'(CYCLES);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      active_q <= (cnt_d != '0);
    end
  end

  assign active = active_q;

endmodule

// file: logic/hm_ctrl_status.sv
// hardware monitor control and status registers behind an address pointer
// assumes a serial bus engine on link_clk issuing pointer writes, data writes and reads
//
// What this block does
// R1 - channel mode bits 0,1 pick analogue input when set, tachometer when clear
// R2 - channel mode bit 2 turns 2.5V/core supply two into second diode input
// R3 - channel mode bit 3 selects 5.0V supply scaling, clear selects 3.3V
// R4 - mode bits 4..6 enable external requests, effective only with bit 7 set
// R5 - mode bit 7 makes voltage-code inputs act as interrupt request inputs
// R6 - configuration bit 0 starts monitoring; clear puts device in standby
// R7 - clearing start after an interrupt leaves interrupt outputs asserted
// R8 - starting begins scanning and limit checks; host sets limits beforehand
// R9 - configuration bit 1 enables general interrupt output, else inactive
// R10 - configuration bit 2 enables thermal interrupt output, else inactive
// R11 - configuration bit 3 forces general interrupt off, halts monitoring, keeps status
// R12 - configuration bit 4 drives reset output low 20 ms, then self-clears
// R13 - configuration bit 6 forces thermal output off, status untouched
// R14 - configuration bit 7 reloads defaults of listed registers, then self-clears
// R15 - status bits flag voltage or temperature outside high/low limits
// R16 - first status bits 6,7 flag fan count or analogue window violations
// R17 - second status bit 4 set after case open input went high
// R18 - second status bit 5 set when thermal line pulled low externally
// R19 - second status bits 6,7 flag first and second remote diode faults
// R20 - mask bits keep matching status bits off the general interrupt
// R21 - host writes eight-bit address pointer, reset zero, before access
// R22 - general interrupt low when unmasked status set, enabled, not cleared
`timescale 1ns/1ps
module hm_ctrl_status #(
  parameter int unsigned RESET_PULSE_CYCLES = hm_pkg::RESET_PULSE_CYCLES
) (
  // core clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // serial bus engine side, on the link clock
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire logic       link_ptr_wr,
  input  wire logic       link_data_wr,
  input  wire logic       link_rd,
  input  wire logic [7:0] link_wdata,
  output logic            link_busy,
  output logic      [7:0] link_rdata,
  output logic            link_rdata_valid,
  // limit comparison results, same clock
  input  wire logic [5:0] limit_violation1,
  input  wire logic [1:0] limit_violation2,
  input  wire logic [1:0] fan_over_limit,
  input  wire logic [1:0] analog_over_limit,
  input  wire logic [1:0] diode_fault,
  // mask registers held elsewhere, same clock
  input  wire logic [7:0] int_mask1,
  input  wire logic [7:0] int_mask2,
  // pins
  input  wire logic       case_open_detect,
  input  wire logic [2:0] ext_request,
  input  wire logic       thermal_alarm_n_i,
  output logic            thermal_alarm_n_o,
  output logic            thermal_alarm_n_oe,
  output logic            int_n,
  output logic            reset_out_n,
  // mode controls for the measurement engine
  output logic            tach_or_analog_in_one,
  output logic            tach_or_analog_in_two,
  output logic            second_diode_mode,
  output logic            supply_range_5v,
  output logic            voltage_code_or_request_select,
  output logic            monitor_run,
  output logic            soft_defaults_restore
);

  // link domain
  hm_pkg::hm_link_state_type lk_state_q;
  hm_pkg::hm_op_type         lk_op_q;
  logic [7:0]                lk_wdata_q;
  logic                      lk_req_tgl_q;
  logic                      lk_ack_seen_q;
  logic                      lk_ack_sync;
  logic [7:0]                lk_rdata_q;
  logic                      lk_rvalid_q;
  logic                      lk_ack_pulse;

  // core domain
  logic       req_sync;
  logic       req_seen_q;
  logic       req_pulse;
  logic       ack_tgl_q;
  logic [7:0] core_rdata_q;
  logic [7:0] ptr_q;
  logic [7:0] cm_q;
  logic [7:0] cfg_q;
  logic [7:0] stat1_q;
  logic [7:0] stat2_q;
  logic [7:0] stat1_set;
  logic [7:0] stat2_set;
  logic [4:0] pins_sync;
  logic [2:0] req_eff;
  logic       run;
  logic       wr_cfg;
  logic       defaults_hit;
  logic       pulse_start;
  logic       pulse_active;
  logic       int_n_q;
  logic       thermal_alarm_n_act_q;
  logic [1:0] thermal_alarm_n_act_dly_q;
  logic       defaults_q;
  logic       case_open_s;
  logic       thermal_low_s;

  function automatic logic addr_hit(input logic [7:0] ptr, input logic [7:0] addr);
    addr_hit = (ptr == addr);
  endfunction

  // link side: one access in flight; data stay stable until the ack returns
  assign lk_ack_pulse = lk_ack_sync ^ lk_ack_seen_q;

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      lk_state_q    <= hm_pkg::LK_IDLE;
      lk_op_q       <= hm_pkg::OP_READ;
      lk_wdata_q    <= 8'h00;
      lk_req_tgl_q  <= 1'b0;
      lk_ack_seen_q <= 1'b0;
      lk_rdata_q    <= 8'h00;
      lk_rvalid_q   <= 1'b0;
    end
    else
    begin
      lk_ack_seen_q <= lk_ack_sync;
      lk_rvalid_q   <= 1'b0;
      case (lk_state_q)
        hm_pkg::LK_IDLE:
        begin
          if (link_ptr_wr || link_data_wr || link_rd)
          begin
            if (link_ptr_wr)
              lk_op_q <= hm_pkg::OP_PTR;
            else if (link_data_wr)
              lk_op_q <= hm_pkg::OP_WRITE;
            else
              lk_op_q <= hm_pkg::OP_READ;
            lk_wdata_q   <= link_wdata;
            lk_req_tgl_q <= ~lk_req_tgl_q;
            lk_state_q   <= hm_pkg::LK_WAIT;
          end
        end
        hm_pkg::LK_WAIT:
        begin
          if (lk_ack_pulse)
          begin
            lk_rdata_q  <= core_rdata_q;
            lk_rvalid_q <= (lk_op_q == hm_pkg::OP_READ);
            lk_state_q  <= hm_pkg::LK_IDLE;
          end
        end
        default:
          lk_state_q <= hm_pkg::LK_IDLE;
      endcase
    end
  end

  hm_sync_bus #(.W(1)) u_ack_sync (
    .clk (link_clk),
    .rst (link_rst),
    .d   (ack_tgl_q),
    .q   (lk_ack_sync)
  );

  assign link_busy        = (lk_state_q == hm_pkg::LK_WAIT);
  assign link_rdata       = lk_rdata_q;
  assign link_rdata_valid = lk_rvalid_q;

  // core side of the request crossing
  hm_sync_bus #(.W(1)) u_req_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   (lk_req_tgl_q),
    .q   (req_sync)
  );

  // thermal line enters inverted so the flops' reset value matches its idle level
  hm_sync_bus #(.W(5)) u_pin_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({ext_request, case_open_detect, ~thermal_alarm_n_i}),
    .q   (pins_sync)
  );

  assign req_pulse     = req_sync ^ req_seen_q;
  assign case_open_s   = pins_sync[1];
  // own drive reads back as a pull for two more clocks through the synchroniser
  assign thermal_low_s = pins_sync[0] & ~thermal_alarm_n_act_q & ~(|thermal_alarm_n_act_dly_q);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
    end
    else
    begin
      req_seen_q <= req_sync;
      ack_tgl_q  <= ack_tgl_q ^ req_pulse;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ptr_q <= hm_pkg::RST_POINTER;
    else if (req_pulse && lk_op_q == hm_pkg::OP_PTR)
      ptr_q <= lk_wdata_q; // R21
  end

  assign wr_cfg       = req_pulse && lk_op_q == hm_pkg::OP_WRITE
                        && addr_hit(ptr_q, hm_pkg::ADDR_CONFIG);
  assign defaults_hit = wr_cfg && lk_wdata_q[hm_pkg::CFG_DEFAULTS];
  assign pulse_start  = wr_cfg && lk_wdata_q[hm_pkg::CFG_RESET_OUT] && !defaults_hit;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cm_q <= hm_pkg::RST_CHANNEL_MODE;
    else if (req_pulse && lk_op_q == hm_pkg::OP_WRITE
             && addr_hit(ptr_q, hm_pkg::ADDR_CHANNEL_MODE))
      cm_q <= lk_wdata_q;
  end

  // reset-out and restore bits are actions, not stored state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cfg_q <= hm_pkg::RST_CONFIG;
    else if (defaults_hit)
      cfg_q <= hm_pkg::RST_CONFIG; // R14
    else if (wr_cfg)
    begin
      cfg_q <= lk_wdata_q;
      cfg_q[hm_pkg::CFG_RESET_OUT] <= 1'b0;
      cfg_q[hm_pkg::CFG_DEFAULTS]  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      defaults_q <= 1'b0;
    else
      defaults_q <= defaults_hit; // R14
  end

  hm_pulse_timer #(.CYCLES(RESET_PULSE_CYCLES)) u_reset_pulse (
    .clk    (ref_clk),
    .rst    (sys_rst),
    .start  (pulse_start),
    .active (pulse_active)
  );

  // clear bit halts scanning; status sets other than case open stop with it
  assign run = cfg_q[hm_pkg::CFG_START] && !cfg_q[hm_pkg::CFG_INT_CLEAR]; // R6 R8 R11

  always_comb
  begin
    stat1_set = 8'h00;
    stat2_set = 8'h00;
    if (run)
    begin
      stat1_set[5:0] = limit_violation1; // R15
      stat1_set[hm_pkg::ST1_IN1] = cm_q[hm_pkg::CM_IN1_ANALOG]
                                 ? analog_over_limit[0] : fan_over_limit[0]; // R16 R1
      stat1_set[hm_pkg::ST1_IN1 + 1] = cm_q[hm_pkg::CM_IN2_ANALOG]
                                     ? analog_over_limit[1] : fan_over_limit[1]; // R16 R1
      stat2_set[1:0] = limit_violation2; // R15
      stat2_set[hm_pkg::ST2_THERMAL] = thermal_low_s; // R18
      stat2_set[hm_pkg::ST2_DIODE1]  = diode_fault[0]; // R19
      stat2_set[hm_pkg::ST2_DIODE2]  = diode_fault[1] && cm_q[hm_pkg::CM_DIODE2]; // R19 R2
    end
    // intrusion latches even in standby
    stat2_set[hm_pkg::ST2_CASE_OPEN] = case_open_s; // R17
  end

  // clear on read; a set in the same cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stat1_q <= hm_pkg::RST_STATUS;
      stat2_q <= hm_pkg::RST_STATUS;
    end
    else if (defaults_hit)
    begin
      stat1_q <= stat1_set; // R14
      stat2_q <= stat2_set;
    end
    else
    begin
      if (req_pulse && lk_op_q == hm_pkg::OP_READ
          && addr_hit(ptr_q, hm_pkg::ADDR_STATUS1))
        stat1_q <= stat1_set;
      else
        stat1_q <= stat1_q | stat1_set;
      if (req_pulse && lk_op_q == hm_pkg::OP_READ
          && addr_hit(ptr_q, hm_pkg::ADDR_STATUS2))
        stat2_q <= stat2_set;
      else
        stat2_q <= stat2_q | stat2_set;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      core_rdata_q <= 8'h00;
    else if (req_pulse && lk_op_q == hm_pkg::OP_READ)
    begin
      if (addr_hit(ptr_q, hm_pkg::ADDR_CHANNEL_MODE))
        core_rdata_q <= cm_q;
      else if (addr_hit(ptr_q, hm_pkg::ADDR_CONFIG))
        core_rdata_q <= cfg_q | {3'b000, pulse_active || pulse_start, 4'h0}; // R12
      else if (addr_hit(ptr_q, hm_pkg::ADDR_STATUS1))
        core_rdata_q <= stat1_q;
      else if (addr_hit(ptr_q, hm_pkg::ADDR_STATUS2))
        core_rdata_q <= stat2_q;
      else
        core_rdata_q <= 8'h00;
    end
  end

  assign req_eff = pins_sync[4:2] & cm_q[hm_pkg::CM_REQ0_EN +: 3]
                   & {3{cm_q[hm_pkg::CM_REQ_SELECT]}}; // R4 R5

  // int follows status, not start, so standby keeps it asserted
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      int_n_q <= 1'b1;
    else
      int_n_q <= !(cfg_q[hm_pkg::CFG_INT_EN] && !cfg_q[hm_pkg::CFG_INT_CLEAR]
                   && ((|(stat1_q & ~int_mask1)) || (|(stat2_q & ~int_mask2))
                       || (|req_eff))); // R22 R20 R9 R11 R7
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      thermal_alarm_n_act_q <= 1'b0;
    else
      thermal_alarm_n_act_q <= cfg_q[hm_pkg::CFG_THERMAL_ALARM_N_EN] && !cfg_q[hm_pkg::CFG_THERMAL_ALARM_N_HOLD]
                     && (stat1_q[hm_pkg::ST1_INT_TEMP] || stat1_q[hm_pkg::ST1_EXT_TEMP]); // R10 R13
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      thermal_alarm_n_act_dly_q <= 2'b00;
    else
      thermal_alarm_n_act_dly_q <= {thermal_alarm_n_act_dly_q[0], thermal_alarm_n_act_q}; // R18
  end

  assign int_n                          = int_n_q;
  assign thermal_alarm_n_o              = 1'b0;
  assign thermal_alarm_n_oe             = thermal_alarm_n_act_q;
  assign reset_out_n                    = !pulse_active; // R12
  assign tach_or_analog_in_one          = cm_q[hm_pkg::CM_IN1_ANALOG]; // R1
  assign tach_or_analog_in_two          = cm_q[hm_pkg::CM_IN2_ANALOG]; // R1
  assign second_diode_mode              = cm_q[hm_pkg::CM_DIODE2]; // R2
  assign supply_range_5v                = cm_q[hm_pkg::CM_RANGE_5V]; // R3
  assign voltage_code_or_request_select = cm_q[hm_pkg::CM_REQ_SELECT]; // R5
  assign monitor_run                    = run;
  assign soft_defaults_restore          = defaults_q;

  // checks
  logic [31:0] low_cnt_q;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || reset_out_n)
      low_cnt_q <= 32'h0000_0000;
    else
      low_cnt_q <= low_cnt_q + 32'h0000_0001;
  end

  a_int_disabled: assert property (@(posedge ref_clk) disable iff (sys_rst) // R9
    !cfg_q[hm_pkg::CFG_INT_EN] |=> int_n)
    else $error("general interrupt active while disabled");
  a_int_clear_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
    cfg_q[hm_pkg::CFG_INT_CLEAR] && !req_pulse |=> int_n && $stable(stat1_q)
      && !monitor_run)
    else $error("clear bit did not halt and silence");
  a_thermal_alarm_n_disabled: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
    !cfg_q[hm_pkg::CFG_THERMAL_ALARM_N_EN] |=> !thermal_alarm_n_oe)
    else $error("thermal output active while disabled");
  a_thermal_alarm_n_hold_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    cfg_q[hm_pkg::CFG_THERMAL_ALARM_N_HOLD] && !req_pulse |=> !thermal_alarm_n_oe
      && (stat1_q & $past(stat1_q)) == $past(stat1_q))
    else $error("thermal hold off failed");
  a_reset_pulse_start: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    pulse_start && reset_out_n |=> ##1 !reset_out_n [*2])
    else $error("reset pulse did not start");
  a_reset_pulse_len: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    $rose(reset_out_n) |-> low_cnt_q == RESET_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_defaults_reload: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
    defaults_hit |=> cfg_q == hm_pkg::RST_CONFIG
      && (stat1_q & ~$past(stat1_set)) == hm_pkg::RST_STATUS
      && soft_defaults_restore ##1 !soft_defaults_restore)
    else $error("defaults not restored");
  a_status_limit: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
    run && limit_violation1[0] |=> stat1_q[0])
    else $error("limit violation not flagged");
  a_in1_analog_sel: assert property (@(posedge ref_clk) disable iff (sys_rst) // R16
    run && cm_q[hm_pkg::CM_IN1_ANALOG] && analog_over_limit[0] |=> stat1_q[hm_pkg::ST1_IN1])
    else $error("analogue window violation not flagged");
  a_case_open_flag: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
    case_open_s |=> stat2_q[hm_pkg::ST2_CASE_OPEN])
    else $error("case open not flagged");
  a_request_gate: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    cfg_q[hm_pkg::CFG_INT_EN] && !cfg_q[hm_pkg::CFG_INT_CLEAR] && |req_eff |=> !int_n)
    else $error("enabled request did not interrupt");
  a_pointer_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R21
    req_pulse && lk_op_q == hm_pkg::OP_PTR |=> ptr_q == $past(lk_wdata_q))
    else $error("pointer not loaded");

  c_reset_pulse: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(reset_out_n));
  c_defaults:    cover property (@(posedge ref_clk) disable iff (sys_rst) defaults_hit);
  c_int_assert:  cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(int_n));
  c_standby_int: cover property (@(posedge ref_clk) disable iff (sys_rst)
    !int_n && !cfg_q[hm_pkg::CFG_START]);

endmodule

// file: verification/hm_link_host.sv
// host model on the serial engine side: pointer writes, data writes, reads
// assumes link_busy drops within a few link_clk cycles of a taken request
`timescale 1ns/1ps
module hm_link_host (
  // link clock and answers from the block
  input  wire logic       link_clk,
  input  wire logic       link_busy,
  input  wire logic [7:0] link_rdata,
  input  wire logic       link_rdata_valid,
  // requests to the block
  output logic            link_ptr_wr,
  output logic            link_data_wr,
  output logic            link_rd,
  output logic      [7:0] link_wdata
);
  int fails = 0;

  initial
  begin
    link_ptr_wr  = 1'b0;
    link_data_wr = 1'b0;
    link_rd      = 1'b0;
    link_wdata   = 8'h00;
  end

  // request held up to the taking edge; afterwards the data lines carry junk
  task automatic access(input hm_pkg::hm_op_type op, input logic [7:0] wd,
                        output logic [7:0] rd);
    int n;
    n = 0;
    rd = 8'h00;
    @(posedge link_clk);
    #1;
    link_ptr_wr  = (op == hm_pkg::OP_PTR);
    link_data_wr = (op == hm_pkg::OP_WRITE);
    link_rd      = (op == hm_pkg::OP_READ);
    link_wdata   = wd;
    @(posedge link_clk);
    #1;
    link_ptr_wr  = 1'b0;
    link_data_wr = 1'b0;
    link_rd      = 1'b0;
    link_wdata   = ~wd;
    while (link_busy !== 1'b0 && n < 12)
    begin
      @(posedge link_clk);
      #1;
      if (link_rdata_valid === 1'b1)
        rd = link_rdata;
      n++;
    end
    if (n >= 12)
      fails++;
  endtask
endmodule

// file: verification/hm_ctrl_status_tb.sv
// self-checking bench for the monitor control and status registers
// assumes hm_link_host drives the link side; pulse length shortened to PULSE
`timescale 1ns/1ps
module hm_ctrl_status_tb;
  localparam int unsigned PULSE = 20;
  logic ref_clk = 0, sys_rst = 1, link_clk = 0, link_rst = 1;
  logic link_ptr_wr, link_data_wr, link_rd, link_busy, link_rdata_valid;
  logic [7:0] link_wdata, link_rdata, int_mask1 = 0, int_mask2 = 0;
  logic [5:0] limit_violation1 = 0;
  logic [1:0] limit_violation2 = 0, fan_over_limit = 0, analog_over_limit = 0;
  logic [1:0] diode_fault = 0;
  logic [2:0] ext_request = 0;
  logic case_open_detect = 0, thermal_alarm_n_pull = 0, thermal_alarm_n_i, thermal_alarm_n_oe;
  logic int_n, reset_out_n, tach_or_analog_in_one, tach_or_analog_in_two;
  logic second_diode_mode, supply_range_5v, voltage_code_or_request_select;
  logic monitor_run, soft_defaults_restore, thermal_alarm_n_o;
  int miscompares = 0, compares = 0, cyc = 0, low_cnt = 0, rst_cnt = 0;

  // open-drain thermal line with pull-up
  assign thermal_alarm_n_i = ~((thermal_alarm_n_oe & ~thermal_alarm_n_o) | thermal_alarm_n_pull);

  hm_ctrl_status #(.RESET_PULSE_CYCLES(PULSE)) u_hm_ctrl_status (
    .ref_clk, .sys_rst, .link_clk, .link_rst, .link_ptr_wr, .link_data_wr,
    .link_rd, .link_wdata, .link_busy, .link_rdata, .link_rdata_valid,
    .limit_violation1, .limit_violation2, .fan_over_limit, .analog_over_limit,
    .diode_fault, .int_mask1, .int_mask2, .case_open_detect, .ext_request,
    .thermal_alarm_n_i, .thermal_alarm_n_o, .thermal_alarm_n_oe, .int_n,
    .reset_out_n, .tach_or_analog_in_one, .tach_or_analog_in_two,
    .second_diode_mode, .supply_range_5v, .voltage_code_or_request_select,
    .monitor_run, .soft_defaults_restore);

  hm_link_host u_hm_link_host (
    .link_clk, .link_busy, .link_rdata, .link_rdata_valid,
    .link_ptr_wr, .link_data_wr, .link_rd, .link_wdata);

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // link clock deliberately out of phase with ref_clk
  initial
  begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  always @(posedge ref_clk)
  begin
    if (reset_out_n === 1'b0) low_cnt++;
    if (soft_defaults_restore === 1'b1) rst_cnt++;
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    miscompares += u_hm_link_host.fails;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_hm_link_host.access(hm_pkg::OP_PTR, a, r);
    u_hm_link_host.access(hm_pkg::OP_WRITE, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_hm_link_host.access(hm_pkg::OP_PTR, a, r);
    u_hm_link_host.access(hm_pkg::OP_READ, 8'h00, r);
    chk(r, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    rchk(hm_pkg::ADDR_CHANNEL_MODE, 8'h08);
    rchk(hm_pkg::ADDR_CONFIG, 8'h08);
    rchk(hm_pkg::ADDR_STATUS1, 8'h00);
    rchk(hm_pkg::ADDR_STATUS2, 8'h00);
    chk({supply_range_5v, monitor_run, int_n, reset_out_n, 4'h0}, 8'hb0);
    wr(8'h3e, 8'h5a);
    rchk(8'h3e, 8'h00);
    wr(hm_pkg::ADDR_STATUS1, 8'hff);
    rchk(hm_pkg::ADDR_STATUS1, 8'h00);
  endtask

  task automatic t_mode();
    logic [7:0] v [2] = '{8'h87, 8'h78};
    foreach (v[i])
    begin
      wr(hm_pkg::ADDR_CHANNEL_MODE, v[i]);
      tick(1);
      chk({3'h0, voltage_code_or_request_select, supply_range_5v, second_diode_mode,
           tach_or_analog_in_two, tach_or_analog_in_one},
          {3'h0, v[i][7], v[i][3], v[i][2], v[i][1], v[i][0]});
      rchk(hm_pkg::ADDR_CHANNEL_MODE, v[i]);
    end
  endtask

  task automatic t_int();
    wr(hm_pkg::ADDR_CHANNEL_MODE, 8'h00);
    wr(hm_pkg::ADDR_CONFIG, 8'h03);
    tick(1);
    chk({7'h0, monitor_run}, 8'h01);
    limit_violation1 = 6'h01;
    fan_over_limit = 2'b01;
    tick(3);
    limit_violation1 = 6'h00;
    fan_over_limit = 2'b00;
    tick(3);
    chk({7'h0, int_n}, 8'h00);
    wr(hm_pkg::ADDR_CONFIG, 8'h02);
    tick(2);
    chk({6'h0, monitor_run, int_n}, 8'h00);
    wr(hm_pkg::ADDR_CONFIG, 8'h0a);
    tick(2);
    chk({7'h0, int_n}, 8'h01);
    rchk(hm_pkg::ADDR_STATUS1, 8'h41);
    wr(hm_pkg::ADDR_CHANNEL_MODE, 8'h01);
    wr(hm_pkg::ADDR_CONFIG, 8'h03);
    int_mask1 = 8'hc2;
    limit_violation1 = 6'h02;
    analog_over_limit = 2'b01;
    fan_over_limit = 2'b10;
    tick(3);
    limit_violation1 = 6'h00;
    analog_over_limit = 2'b00;
    fan_over_limit = 2'b00;
    tick(3);
    chk({7'h0, int_n}, 8'h01);
    rchk(hm_pkg::ADDR_STATUS1, 8'hc2);
    int_mask1 = 8'h00;
  endtask

  task automatic t_thermal_alarm_n();
    wr(hm_pkg::ADDR_CONFIG, 8'h05);
    limit_violation1 = 6'h10;
    tick(3);
    limit_violation1 = 6'h00;
    tick(3);
    chk({6'h0, thermal_alarm_n_oe, int_n}, 8'h03);
    wr(hm_pkg::ADDR_CONFIG, 8'h45);
    tick(2);
    chk({7'h0, thermal_alarm_n_oe}, 8'h00);
    rchk(hm_pkg::ADDR_STATUS1, 8'h10);
    rchk(hm_pkg::ADDR_STATUS2, 8'h00);
  endtask

  task automatic t_stat2();
    wr(hm_pkg::ADDR_CHANNEL_MODE, 8'h04);
    wr(hm_pkg::ADDR_CONFIG, 8'h01);
    case_open_detect = 1;
    thermal_alarm_n_pull = 1;
    diode_fault = 2'b11;
    limit_violation2 = 2'b11;
    tick(4);
    case_open_detect = 0;
    thermal_alarm_n_pull = 0;
    diode_fault = 2'b00;
    limit_violation2 = 2'b00;
    tick(4);
    rchk(hm_pkg::ADDR_STATUS2, 8'hf3);
  endtask

  task automatic t_pulse();
    wr(hm_pkg::ADDR_CONFIG, 8'h10);
    tick(3 * PULSE);
    chk(8'(low_cnt), 8'(PULSE));
    rchk(hm_pkg::ADDR_CONFIG, 8'h00);
  endtask

  task automatic t_restore();
    wr(hm_pkg::ADDR_CONFIG, 8'h01);
    limit_violation1 = 6'h04;
    tick(3);
    limit_violation1 = 6'h00;
    wr(hm_pkg::ADDR_CONFIG, 8'h80);
    tick(2);
    chk(8'(rst_cnt), 8'h01);
    rchk(hm_pkg::ADDR_CONFIG, 8'h08);
    rchk(hm_pkg::ADDR_STATUS1, 8'h00);
  endtask

  task automatic t_ext();
    wr(hm_pkg::ADDR_CHANNEL_MODE, 8'h10);
    wr(hm_pkg::ADDR_CONFIG, 8'h03);
    ext_request = 3'b001;
    tick(4);
    chk({7'h0, int_n}, 8'h01);
    wr(hm_pkg::ADDR_CHANNEL_MODE, 8'h90);
    tick(3);
    chk({7'h0, int_n}, 8'h00);
    ext_request = 3'b110;
    tick(4);
    chk({7'h0, int_n}, 8'h01);
  endtask

  initial
  begin
    repeat (3) @(posedge link_clk);
    #1;
    link_rst = 0;
  end

  initial
  begin
    tick(12);
    sys_rst = 0;
    wait (link_rst == 1'b0);
    t_reset();
    t_mode();
    t_int();
    t_thermal_alarm_n();
    t_stat2();
    t_pulse();
    t_restore();
    t_ext();
    test_done();
  end
endmodule
